// ---- fprra_pkg.sv ----
// Types of the reciprocal approximation unit.
// Assumes fprra_regs.svh for all numeric constants.
package fprra_pkg;

   // Operation select, driven by the decode stage
   typedef enum logic [2:0] {
      OP_RCP_DP,
      OP_RCP_SP,
      OP_RSQ_DP,
      OP_RSQ_SP,
      OP_WIDEN
   } fprra_op_t;

   typedef logic [255:0][7:0] fprra_rtab_t;
   typedef logic [511:0][7:0] fprra_stab_t;

   typedef struct packed {
      logic lo_we;
      logic [31:0] lo;
      logic hi_pend;
      logic [31:0] hi_buf;
      logic hi_we;
      logic [31:0] hi;
      logic fl_vld;
      logic [7:0] fl;
      logic [7:0] sts;
      logic [7:0] msk;
      logic [31:0] rdata;
      logic irq;
   } fprra_state_t;

endpackage

// ---- fprra_regs.svh ----
// Register offsets, flag masks and number-format constants of the
// reciprocal approximation unit; included by its bare name.
`ifndef FPRRA_REGS_SVH
`define FPRRA_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define FPRRA_ADDR_STATUS 4'h0
`define FPRRA_ADDR_MASK 4'h4

// ------------------------------------------------------------
// Exception flag masks (status, mask and flag_bits share them)
// ------------------------------------------------------------
`define FPRRA_F_INVALID 8'h01
`define FPRRA_F_SRC_NAN 8'h02
`define FPRRA_F_DIVZERO 8'h04
`define FPRRA_F_INFRES 8'h08
`define FPRRA_F_OVER 8'h10
`define FPRRA_F_UNDER 8'h20
`define FPRRA_F_INEXACT 8'h40
`define FPRRA_F_SRC_DEN 8'h80
`define FPRRA_F_NONE 8'h00

// ------------------------------------------------------------
// Number formats
// ------------------------------------------------------------
`define FPRRA_NAN_SP 32'h7FFF_FFFF
`define FPRRA_NAN_DP 64'h7FFF_FFFF_FFFF_FFFF
`define FPRRA_BIAS_SP 13'h007F
`define FPRRA_BIAS_DP 13'h03FF
`define FPRRA_EMAX_SP 11'h0FF
`define FPRRA_EMAX_DP 11'h7FF
`define FPRRA_SP_PAD 29

`endif

// ---- fprra_rf_model.sv ----
// Register-file model facing the unit: one source pair, one destination pair.
// Assumes the bench loads src_pair just after a rising edge of ref_clk.
`timescale 1ns/10ps

module fprra_rf_model (
   input wire logic ref_clk, // CPU clock
   input wire logic rst_b, // Asynchronous reset
   input wire logic [63:0] src_pair, // Source register pair
   output logic [31:0] src1_data, // Low word read port
   output logic [31:0] src2_data, // High word read port
   input wire logic res_lo_we, // Low word write
   input wire logic [31:0] res_lo, // Low word
   input wire logic res_hi_we, // High word write
   input wire logic [31:0] res_hi, // High word
   output logic [63:0] dst_pair // Destination register pair
);
   // Whole pair offered in one cycle on both read ports
   assign src1_data = src_pair[31:0];
   assign src2_data = src_pair[63:32];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dst_pair <= 64'h0;
      end else begin
         if (res_lo_we) begin
            dst_pair[31:0] <= res_lo;
         end
         if (res_hi_we) begin
            dst_pair[63:32] <= res_hi;
         end
      end
   end
endmodule

// ---- fprra_unit.sv ----
// Reciprocal / reciprocal-square-root seed and single-to-double unit.
// Assumes operands from register-file logic on ref_clk, one issue per
// cycle, and a plain register port for the exception status.
//
// Overview of operation
// (RULE_01) Signalling NaN: default NaN, invalid and NaN flags
// (RULE_02) Quiet NaN: default NaN, NaN flag only
// (RULE_03) Reciprocal denormal: signed infinity, five flags
// (RULE_04) Zero source: signed infinity, divide and infinity
// (RULE_05) Reciprocal of infinity: signed zero, no flags
// (RULE_06) Reciprocal underflow: signed zero, inexact and underflow
// (RULE_07) Exact exponent, eight-bit accurate mantissa seed
// (RULE_08) Single reciprocal written in first stage
// (RULE_09) Double source read low and high together
// (RULE_10) Double result: low word, then high word
// (RULE_11) Negative normal root source gives invalid NaN
// (RULE_12) Root of denormal: infinity, divide, inexact, denormal
// (RULE_13) Root of positive infinity gives positive zero
// (RULE_14) Root seed offered in single and double
// (RULE_15) Single-to-double writes low then high word
// (RULE_16) Single-to-double flushes denormal to signed zero
// (RULE_17) Single-to-double infinity sets only infinity flag
// (RULE_18) Failed predicate leaves results and flags unchanged
`timescale 1ns/10ps
`include "fprra_regs.svh"

module fprra_unit import fprra_pkg::*; (
   input wire logic ref_clk, // CPU clock, 100 MHz
   input wire logic rst_b, // Asynchronous reset
   input wire logic issue, // Operation issued this cycle
   input wire logic pred_pass, // Predicate test passed
   input wire fprra_op_t op, // Operation select
   input wire logic [31:0] src1_data, // Low word of double source
   input wire logic [31:0] src2_data, // Single source or high word
   output logic res_lo_we, // Low or single result write
   output logic [31:0] res_lo, // Low or single result word
   output logic res_hi_we, // High result write
   output logic [31:0] res_hi, // High result word
   output logic flag_vld, // Flags of the last operation valid
   output logic [7:0] flag_bits, // Flags of the last operation
   input wire logic [3:0] reg_addr, // Register address
   input wire logic [31:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   output logic [31:0] reg_rdata, // Read data, cycle after strobe
   output logic irq // Unmasked status pending
);

   // ------------------------------------------------------------
   // Seed tables
   // ------------------------------------------------------------
   // Midpoint of each mantissa slice, reciprocal scaled by 512
   function automatic fprra_rtab_t rcp_table();
      fprra_rtab_t t;
      int q;
      for (int i = 0; i < 256; i++) begin
         q = 32'h0004_0000 / (32'h0000_0201 + 2 * i);
         t[i] = 8'(q);
      end
      return t;
   endfunction

   // Index bit 8 picks an odd exponent (source doubled)
   function automatic fprra_stab_t rsq_table();
      fprra_stab_t t;
      int v;
      int n;
      int r;
      int b;
      for (int k = 0; k < 512; k++) begin
         v = (32'h0000_0201 + 2 * (k % 256)) * (k / 256 + 1);
         n = 32'h0800_0000 / v;
         r = 0;
         for (b = 8; b >= 0; b--) begin
            if ((r | (1 << b)) * (r | (1 << b)) <= n) begin
               r = r | (1 << b);
            end
         end
         t[k] = 8'(r);
      end
      return t;
   endfunction

   localparam fprra_rtab_t RCP_TAB = rcp_table();
   localparam fprra_stab_t RSQ_TAB = rsq_table();

   // Builds a result in either precision; single lands in the low word
   function automatic logic [63:0] fp_pack(input logic dp, input logic s,
                                           input logic [10:0] ex,
                                           input logic [51:0] fr);
      if (dp) begin
         fp_pack = {s, ex, fr};
      end else begin
         fp_pack = {32'h0000_0000, s, ex[7:0], fr[51:`FPRRA_SP_PAD]};
      end
   endfunction

   // ------------------------------------------------------------
   // Datapath
   // ------------------------------------------------------------
   logic go;
   logic dp_src;
   logic dp_res;
   logic is_rcp;
   logic is_rsq;
   logic sgn;
   logic [10:0] ex;
   logic [51:0] fr;
   logic [10:0] emax;
   logic [12:0] bias;
   logic zero;
   logic den;
   logic inf;
   logic nan;
   logic snan;
   logic frnz;
   logic odd;
   logic under;
   logic signed [12:0] e;
   logic signed [12:0] rexp;
   logic signed [12:0] rb;
   logic [7:0] mant;
   logic [63:0] dnan;
   logic [63:0] res;
   logic [7:0] flg;

   assign go = issue & pred_pass;

   always_comb begin
      dp_src = (op == OP_RCP_DP) || (op == OP_RSQ_DP);
      dp_res = dp_src || (op == OP_WIDEN);
      is_rcp = (op == OP_RCP_DP) || (op == OP_RCP_SP);
      is_rsq = (op == OP_RSQ_DP) || (op == OP_RSQ_SP);
      sgn = src2_data[31];
      if (dp_src) begin
         ex = src2_data[30:20];
         fr = {src2_data[19:0], src1_data}; // RULE_09
         emax = `FPRRA_EMAX_DP;
         bias = `FPRRA_BIAS_DP;
      end else begin
         ex = {3'h0, src2_data[30:23]};
         fr = {src2_data[22:0], {`FPRRA_SP_PAD{1'b0}}};
         emax = `FPRRA_EMAX_SP;
         bias = `FPRRA_BIAS_SP;
      end
      frnz = |fr;
      zero = (ex == 11'h000) && !frnz;
      den = (ex == 11'h000) && frnz;
      inf = (ex == emax) && !frnz;
      nan = (ex == emax) && frnz;
      snan = nan && !fr[51];
      e = $signed({2'h0, ex}) - $signed(bias);
      odd = e[0];
      if (is_rsq) begin
         // Exact power of four needs no seed; its exponent is halved and negated with no decrement
         rexp = -(e >>> 1) - $signed({12'h000, frnz | odd}); // RULE_07 RULE_14
         mant = (frnz | odd) ? RSQ_TAB[{odd, fr[51:44]}] : 8'h00;
      end else begin
         rexp = -e - $signed({12'h000, frnz}); // RULE_07
         mant = frnz ? RCP_TAB[fr[51:44]] : 8'h00;
      end
      rb = rexp + $signed(bias);
      under = is_rcp && (rb <= 13'sh0000) && !(zero || den || inf || nan); // RULE_06
      dnan = dp_res ? `FPRRA_NAN_DP : {32'h0000_0000, `FPRRA_NAN_SP};
      res = fp_pack(dp_res, sgn, rb[10:0], {mant, 44'h000_0000_0000});
      flg = `FPRRA_F_NONE;
      if (nan) begin
         res = dnan;
         flg = snan ? (`FPRRA_F_INVALID | `FPRRA_F_SRC_NAN) : `FPRRA_F_SRC_NAN; // RULE_01 RULE_02
      end else begin
         unique case (op)
            OP_WIDEN: begin
               if (den) begin
                  res = fp_pack(1'b1, sgn, 11'h000, 52'h0); // RULE_16
                  flg = `FPRRA_F_INEXACT | `FPRRA_F_SRC_DEN; // RULE_16
               end else if (inf) begin
                  res = fp_pack(1'b1, sgn, `FPRRA_EMAX_DP, 52'h0);
                  flg = `FPRRA_F_INFRES; // RULE_17
               end else if (zero) begin
                  res = fp_pack(1'b1, sgn, 11'h000, 52'h0);
               end else begin
                  res = fp_pack(1'b1, sgn, 11'(e + `FPRRA_BIAS_DP), fr); // RULE_15
               end
            end
            OP_RCP_DP, OP_RCP_SP: begin
               if (den) begin
                  res = fp_pack(dp_res, sgn, emax, 52'h0);
                  flg = `FPRRA_F_DIVZERO | `FPRRA_F_INFRES | `FPRRA_F_OVER
                        | `FPRRA_F_INEXACT | `FPRRA_F_SRC_DEN; // RULE_03
               end else if (zero) begin
                  res = fp_pack(dp_res, sgn, emax, 52'h0);
                  flg = `FPRRA_F_DIVZERO | `FPRRA_F_INFRES; // RULE_04
               end else if (inf) begin
                  res = fp_pack(dp_res, sgn, 11'h000, 52'h0); // RULE_05
               end else if (under) begin
                  res = fp_pack(dp_res, sgn, 11'h000, 52'h0); // RULE_06
                  flg = `FPRRA_F_INEXACT | `FPRRA_F_UNDER; // RULE_06
               end
            end
            OP_RSQ_DP, OP_RSQ_SP: begin
               if (den) begin
                  res = fp_pack(dp_res, sgn, emax, 52'h0);
                  flg = `FPRRA_F_DIVZERO | `FPRRA_F_INEXACT | `FPRRA_F_SRC_DEN; // RULE_12
               end else if (zero) begin
                  res = fp_pack(dp_res, sgn, emax, 52'h0);
                  flg = `FPRRA_F_DIVZERO | `FPRRA_F_INFRES; // RULE_04
               end else if (sgn) begin
                  res = dnan;
                  flg = `FPRRA_F_INVALID; // RULE_11
               end else if (inf) begin
                  res = fp_pack(dp_res, 1'b0, 11'h000, 52'h0); // RULE_13
               end
            end
            default: begin
               res = dnan;
               flg = `FPRRA_F_NONE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   fprra_state_t s_reg;
   fprra_state_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.lo_we = go; // RULE_08 RULE_18
      s_next.fl_vld = go; // RULE_18
      if (go) begin
         s_next.lo = res[31:0]; // RULE_08
         s_next.hi_buf = res[63:32];
         s_next.fl = flg;
      end
      s_next.hi_pend = go && dp_res; // RULE_10 RULE_15
      s_next.hi_we = s_reg.hi_pend; // RULE_10
      if (s_reg.hi_pend) begin
         s_next.hi = s_reg.hi_buf;
      end
      if (reg_wr && (reg_addr == `FPRRA_ADDR_MASK)) begin
         s_next.msk = reg_wdata[7:0];
      end
      s_next.rdata = 32'h0000_0000;
      if (reg_rd && (reg_addr == `FPRRA_ADDR_STATUS)) begin
         s_next.rdata = {24'h00_0000, s_reg.sts};
         s_next.sts = 8'h00;
      end else if (reg_rd && (reg_addr == `FPRRA_ADDR_MASK)) begin
         s_next.rdata = {24'h00_0000, s_reg.msk};
      end
      // A new flag beats a read-clear in the same cycle
      if (go) begin
         s_next.sts = s_next.sts | flg; // RULE_18
      end
      s_next.irq = |(s_next.sts & s_next.msk);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign res_lo_we = s_reg.lo_we;
   assign res_lo = s_reg.lo;
   assign res_hi_we = s_reg.hi_we;
   assign res_hi = s_reg.hi;
   assign flag_vld = s_reg.fl_vld;
   assign flag_bits = s_reg.fl;
   assign reg_rdata = s_reg.rdata;
   assign irq = s_reg.irq;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence seq_dp_go;
      go && dp_res;
   endsequence

   sequence seq_two_words;
      res_lo_we ##1 res_hi_we;
   endsequence

   a_pred_nop: assert property ( // RULE_18
      issue && !pred_pass |=> !res_lo_we && !flag_vld && $stable(res_lo))
      else $error("failed predicate changed results");
   a_sp_one_cycle: assert property ( // RULE_08
      go && !dp_res |=> res_lo_we && flag_vld)
      else $error("single result not written in first stage");
   a_dp_two_words: assert property ( // RULE_10
      seq_dp_go |=> seq_two_words)
      else $error("double result words out of order");
   a_snan_flags: assert property ( // RULE_01
      go && snan |=> flag_bits == (`FPRRA_F_INVALID | `FPRRA_F_SRC_NAN)
         && res_lo == $past(dnan[31:0]))
      else $error("signalling NaN handling wrong");
   a_qnan_flags: assert property ( // RULE_02
      go && nan && !snan |=> flag_bits == `FPRRA_F_SRC_NAN)
      else $error("quiet NaN flags wrong");
   a_rcp_denorm: assert property ( // RULE_03
      go && is_rcp && den |=> flag_bits == (`FPRRA_F_DIVZERO | `FPRRA_F_INFRES
         | `FPRRA_F_OVER | `FPRRA_F_INEXACT | `FPRRA_F_SRC_DEN))
      else $error("reciprocal denormal flags wrong");
   a_zero_src: assert property ( // RULE_04
      go && (is_rcp || is_rsq) && zero
         |=> flag_bits == (`FPRRA_F_DIVZERO | `FPRRA_F_INFRES))
      else $error("zero source flags wrong");
   a_rcp_inf: assert property ( // RULE_05
      go && is_rcp && inf |=> flag_bits == `FPRRA_F_NONE
         && res_lo[30:0] == 31'h0000_0000)
      else $error("reciprocal of infinity wrong");
   a_rcp_under: assert property ( // RULE_06
      go && under |=> flag_bits == (`FPRRA_F_INEXACT | `FPRRA_F_UNDER))
      else $error("underflow flags wrong");
   a_rsq_neg: assert property ( // RULE_11
      go && is_rsq && sgn && !zero && !den && !nan |=> flag_bits == `FPRRA_F_INVALID)
      else $error("negative root source not invalid");
   a_rsq_denorm: assert property ( // RULE_12
      go && is_rsq && den
         |=> flag_bits == (`FPRRA_F_DIVZERO | `FPRRA_F_INEXACT | `FPRRA_F_SRC_DEN))
      else $error("root denormal flags wrong");
   a_rsq_pinf: assert property ( // RULE_13
      go && is_rsq && inf && !sgn |=> res_lo == 32'h0000_0000 && flag_bits == `FPRRA_F_NONE)
      else $error("root of positive infinity not zero");
   a_single_to_double_convert_denorm: assert property ( // RULE_16
      go && (op == OP_WIDEN) && den |=> flag_bits == (`FPRRA_F_INEXACT | `FPRRA_F_SRC_DEN)
         ##1 res_hi[30:0] == 31'h0000_0000)
      else $error("denormal not flushed on widening");
   a_single_to_double_convert_noover: assert property ( // RULE_17
      go && (op == OP_WIDEN) |=> (flag_bits & (`FPRRA_F_OVER | `FPRRA_F_UNDER)) == 8'h00)
      else $error("widening raised overflow or underflow");

endmodule

// ---- fprra_unit_tb.sv ----
// Self-checking bench of the reciprocal approximation unit.
// Assumes fprra_unit, fprra_rf_model and the shared constant header.
`timescale 1ns/10ps
`include "fprra_regs.svh"

module fprra_unit_tb import fprra_pkg::*;;
   typedef struct {int due; logic [31:0] v; logic [7:0] f;} fprra_note_t;
   localparam logic [7:0] FI = `FPRRA_F_INVALID, FN = `FPRRA_F_SRC_NAN, FD = `FPRRA_F_DIVZERO;
   localparam logic [7:0] FO = `FPRRA_F_INFRES, FV = `FPRRA_F_OVER, FU = `FPRRA_F_UNDER;
   localparam logic [7:0] FX = `FPRRA_F_INEXACT, FM = `FPRRA_F_SRC_DEN;
   localparam logic [63:0] NSP = {32'h0, `FPRRA_NAN_SP}, NDP = `FPRRA_NAN_DP;
   localparam logic [3:0] AST = `FPRRA_ADDR_STATUS, AMK = `FPRRA_ADDR_MASK;
   logic ref_clk = 1'b0, rst_b = 1'b0, issue = 1'b0, pred_pass = 1'b0;
   fprra_op_t op = OP_RCP_DP;
   logic [63:0] src_pair = 64'h0, dst_pair;
   logic [31:0] src1_data, src2_data, res_lo, res_hi, reg_rdata, reg_wdata = 32'h0;
   logic [31:0] rnd = 32'h1641;
   logic [3:0] reg_addr = 4'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, res_lo_we, res_hi_we, flag_vld, irq;
   logic [7:0] flag_bits, sts_exp = 8'h00;
   int fail_count = 0, n_tests = 0, cyc = 0;
   fprra_note_t lo_q[$], hi_q[$], rd_q[$];

   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      rd_d <= reg_rd;
   end

   fprra_rf_model rf_u (.ref_clk(ref_clk), .rst_b(rst_b), .src_pair(src_pair),
      .src1_data(src1_data), .src2_data(src2_data), .res_lo_we(res_lo_we), .res_lo(res_lo),
      .res_hi_we(res_hi_we), .res_hi(res_hi), .dst_pair(dst_pair));
   fprra_unit dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .issue(issue), .pred_pass(pred_pass),
      .op(op), .src1_data(src1_data), .src2_data(src2_data), .res_lo_we(res_lo_we),
      .res_lo(res_lo), .res_hi_we(res_hi_we), .res_hi(res_hi), .flag_vld(flag_vld),
      .flag_bits(flag_bits), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
   endfunction
   function automatic logic sgl_src(input fprra_op_t o);
      return o inside {OP_RCP_SP, OP_RSQ_SP, OP_WIDEN};
   endfunction
   function automatic logic dbl_res(input fprra_op_t o);
      return o inside {OP_RCP_DP, OP_RSQ_DP, OP_WIDEN};
   endfunction

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic complete_run();
      if (fail_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Single sources ride the high word; the low word carries junk
   task automatic go(input fprra_op_t o, input logic p, input logic [63:0] s,
                     input logic [63:0] e, input logic [7:0] f);
      @(posedge ref_clk);
      rnd = lfsr(rnd);
      issue <= 1'b1;
      pred_pass <= p;
      op <= o;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      src_pair <= sgl_src(o) ? {s[31:0], rnd} : s;
      if (p) begin
         lo_q.push_back('{cyc + 2, e[31:0], f});
         if (dbl_res(o)) hi_q.push_back('{cyc + 3, e[63:32], 8'h00});
         sts_exp |= f;
      end
   endtask

   // Write when w is set, else read expecting d
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      issue <= 1'b0;
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) rd_q.push_back('{cyc + 2, d, 8'h00});
   endtask

   task automatic idle(input int n);
      @(posedge ref_clk);
      issue <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n - 1) @(posedge ref_clk);
   endtask

   // Results are taken off the queues as they appear, on the falling edge
   always @(negedge ref_clk) begin
      fprra_note_t n;
      if (rst_b) begin
         chk("flag_vld", res_lo_we, flag_vld);
         if (res_lo_we === 1'b1) begin
            if (lo_q.size() == 0) chk("lo_extra", 0, 1);
            else begin
               n = lo_q.pop_front();
               chk("res_lo", n.v, res_lo);
               chk("flag_bits", n.f, flag_bits);
               chk("lo_time", n.due, cyc);
            end
         end
         if (res_hi_we === 1'b1) begin
            if (hi_q.size() == 0) chk("hi_extra", 0, 1);
            else begin
               n = hi_q.pop_front();
               chk("res_hi", n.v, res_hi);
               chk("hi_time", n.due, cyc);
            end
         end
         if (rd_d) begin
            n = rd_q.pop_front();
            chk("reg_rdata", n.v, reg_rdata);
            chk("rd_time", n.due, cyc);
         end else chk("rdata_idle", 0, reg_rdata);
      end
   end

   initial begin
      #20000;
      fail_count++;
      complete_run();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      fprra_op_t o;
      logic [7:0] e8;
      logic [63:0] dexp;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      bus(0, AST, 32'h0);
      bus(0, AMK, 32'h0);
      bus(0, 4'h8, 32'h0);
      bus(1, AMK, 32'hFFFF_FF01);
      bus(1, AST, 32'hFFFF_FFFF);
      bus(0, AMK, 32'h1);
      bus(0, AST, 32'h0);
      for (int i = 0; i < 5; i++) begin
         o = fprra_op_t'(i);
         go(o, 1, sgl_src(o) ? 64'h7F80_0001 : 64'h7FF0_0000_0000_0001,
            dbl_res(o) ? NDP : NSP, FI | FN);
         go(o, 1, sgl_src(o) ? 64'h7FC0_0000 : 64'h7FF8_0000_0000_0000,
            dbl_res(o) ? NDP : NSP, FN);
      end
      go(OP_RCP_SP, 1, 64'h8000_0001, 64'hFF80_0000, FD | FO | FV | FX | FM);
      go(OP_RCP_DP, 1, 64'h1, 64'h7FF0_0000_0000_0000, FD | FO | FV | FX | FM);
      go(OP_RCP_SP, 1, 64'h8000_0000, 64'hFF80_0000, FD | FO);
      go(OP_RSQ_DP, 1, 64'h0, 64'h7FF0_0000_0000_0000, FD | FO);
      go(OP_RSQ_SP, 1, 64'h8000_0000, 64'hFF80_0000, FD | FO);
      go(OP_RCP_SP, 1, 64'hFF80_0000, 64'h8000_0000, 8'h00);
      go(OP_RCP_DP, 1, 64'h7FF0_0000_0000_0000, 64'h0, 8'h00);
      go(OP_RCP_SP, 1, 64'h7F00_0000, 64'h0, FX | FU);
      go(OP_RCP_DP, 1, 64'h7FE0_0000_0000_0000, 64'h0, FX | FU);
      go(OP_RCP_SP, 1, 64'h7E80_0000, 64'h0080_0000, 8'h00);
      go(OP_RCP_DP, 1, 64'h7FD0_0000_0000_0000, 64'h0010_0000_0000_0000, 8'h00);
      go(OP_RCP_SP, 1, 64'h4000_0000, 64'h3F00_0000, 8'h00);
      go(OP_RCP_DP, 1, 64'h4010_0000_0000_0000, 64'h3FD0_0000_0000_0000, 8'h00);
      go(OP_RSQ_DP, 1, 64'h4010_0000_0000_0000, 64'h3FE0_0000_0000_0000, 8'h00);
      go(OP_RSQ_SP, 1, 64'h4080_0000, 64'h3F00_0000, 8'h00);
      go(OP_RSQ_SP, 1, 64'hC080_0000, NSP, FI);
      go(OP_RSQ_DP, 1, 64'hC010_0000_0000_0000, NDP, FI);
      go(OP_RSQ_SP, 1, 64'h8000_0001, 64'hFF80_0000, FD | FX | FM);
      go(OP_RSQ_DP, 1, 64'h1, 64'h7FF0_0000_0000_0000, FD | FX | FM);
      go(OP_RSQ_SP, 1, 64'h7F80_0000, 64'h0, 8'h00);
      go(OP_RSQ_DP, 1, 64'h7FF0_0000_0000_0000, 64'h0, 8'h00);
      go(OP_WIDEN, 1, 64'h4109_999A, 64'h4021_3333_4000_0000, 8'h00);
      go(OP_WIDEN, 1, 64'h8000_0001, 64'h8000_0000_0000_0000, FX | FM);
      go(OP_WIDEN, 1, 64'hFF80_0000, 64'hFFF0_0000_0000_0000, FO);
      // Midpoint seed of 1/3: exponent exact, eight fraction bits
      go(OP_RCP_SP, 1, 64'h4040_0000, 64'h3EAA_0000, 8'h00);
      idle(5);
      chk("irq", 1, irq);
      bus(0, AST, {24'h0, sts_exp});
      sts_exp = 8'h00;
      idle(5);
      chk("irq", 0, irq);
      bus(1, AMK, 32'h0);
      go(OP_RCP_SP, 1, 64'h7F80_0001, NSP, FI | FN);
      idle(5);
      chk("irq", 0, irq);
      bus(1, AMK, 32'h1);
      idle(5);
      chk("irq", 1, irq);
      bus(0, AST, {24'h0, sts_exp});
      sts_exp = 8'h00;
      idle(5);
      chk("irq", 0, irq);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         e8 = (rnd[30:23] inside {8'h00, 8'hFF}) ? 8'h40 : rnd[30:23];
         dexp = {rnd[31], 11'(e8) + 11'h380, rnd[22:0], 29'h0};
         go(OP_WIDEN, 1, {32'h0, rnd[31], e8, rnd[22:0]}, dexp, 8'h00);
      end
      idle(5);
      chk("dst_pair", dexp, dst_pair);
      go(OP_WIDEN, 0, 64'h7F80_0001, 64'h0, FI | FN);
      idle(5);
      chk("dst_pair", dexp, dst_pair);
      chk("irq", 0, irq);
      bus(0, AST, 32'h0);
      idle(5);
      chk("pending", 0, lo_q.size() + hi_q.size() + rd_q.size());
      complete_run();
   end
endmodule
